// ==== dv/smi_top_level_status_test.sv ====
`timescale 1ns/1ps
module smi_top_level_status_test;
  import smi_status_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic io_rd = 1'b0;
  logic susp_cfg = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [1:0] usb_en = 2'h0;
  smi_evt_t evt = '0;
  smi_l2_clr_t l2_clr = '0;
  logic [GPIO_N-1:0] gpio_evt = '0;
  logic [GPIO_N-1:0] gpio_clr = '0;
  logic [GPIO_N-1:0] gpio_sts;
  logic [GPIO_N-1:0] g;
  logic [15:0] io_rdata_ff;
  logic io_rd_ack_ff;
  logic smi_req;
  logic [15:0] exp_q[$];
  int mismatches = 0;
  int checks = 0;

  // 125 MHz clock
  always #4 mclk = ~mclk;

  smi_top_level_status u_dut (.mclk(mclk), .rst_b(rst_b), .io_rd(io_rd), .io_addr(io_addr),
    .io_rdata_ff(io_rdata_ff), .io_rd_ack_ff(io_rd_ack_ff), .evt(evt), .l2_clr(l2_clr),
    .gpio_evt(gpio_evt), .gpio_clr(gpio_clr), .susp_cfg(susp_cfg), .usb_en(usb_en),
    .gpio_sts(gpio_sts), .smi_req(smi_req));

  // Single compare point; four-state so an unknown never matches
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  // Called at a falling edge; hold keeps the strobe up for a back-to-back read
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input bit hold = 1'b0);
    io_rd = 1'b1;
    io_addr = a;
    exp_q.push_back(e);
    @(negedge mclk);
    if (!hold) io_rd = 1'b0;
  endtask : rd

  // One-cycle pulse on cause and clear inputs
  task automatic pulse(input smi_evt_t e, input smi_l2_clr_t c, input logic [GPIO_N-1:0] ge,
                       input logic [GPIO_N-1:0] gc);
    evt = e;
    l2_clr = c;
    gpio_evt = ge;
    gpio_clr = gc;
    @(negedge mclk);
    evt = '0;
    l2_clr = '0;
    gpio_evt = '0;
    gpio_clr = '0;
  endtask : pulse

  // Ends the run from the main sequence or the watchdog
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // Each acknowledged read takes the oldest note; an ack with no note is a fault
  always @(negedge mclk) begin
    if (io_rd_ack_ff === 1'b1) begin
      chk(io_rdata_ff, exp_q.size() > 0 ? exp_q.pop_front() : 16'hdead);
    end
  end

  // Watchdog, far beyond the expected run of about 34 cycles
  initial begin
    #20000;
    mismatches++;
    give_verdict();
  end

  initial begin
    void'($urandom(19));
    // Four rising edges see reset low before the release
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    rd(OFS_STATUS, STATUS_RST);
    chk(smi_req, 1'b0);
    // USB cause is refused until the enable field is 11
    usb_en = 2'($urandom_range(2, 0));
    pulse(4'h8, 2'h0, '0, '0);
    chk(smi_req, 1'b0);
    usb_en = USB_EN_ON;
    pulse(4'h8, 2'h0, '0, '0);
    chk(smi_req, 1'b1);
    // Warm reset while suspend is configured also raises the suspend hint
    susp_cfg = 1'b1;
    pulse(4'h4, 2'h0, '0, '0);
    susp_cfg = 1'b0;
    rd(OFS_MIRROR, 16'he000);
    chk(smi_req, 1'b1);
    rd(OFS_STATUS, 16'he000, 1'b1);
    rd(OFS_STATUS, 16'h0000);
    chk(smi_req, 1'b0);
    // Audio bit survives reads and falls only with its second-level clear
    pulse(4'h2, 2'h0, '0, '0);
    rd(8'($urandom_range(255, 4)), 16'h0000);
    rd(OFS_STATUS, 16'h0002, 1'b1);
    rd(OFS_STATUS, 16'h0002);
    pulse(4'h0, 2'h2, '0, '0);
    chk(smi_req, 1'b0);
    rd(OFS_STATUS, 16'h0000);
    // Power management and a random GPIO pin share bit 0
    g = GPIO_N'(1) << $urandom_range(GPIO_N - 1, 0);
    pulse(4'h1, 2'h0, g, '0);
    chk(gpio_sts, g);
    rd(OFS_STATUS, 16'h0001);
    pulse(4'h0, 2'h0, '0, g);
    chk(gpio_sts, '0);
    rd(OFS_STATUS, 16'h0001);
    pulse(4'h0, 2'h1, '0, '0);
    rd(OFS_STATUS, 16'h0000);
    // A third-level clear alone drops bit 0 and the request
    pulse(4'h0, 2'h0, g, '0);
    chk(smi_req, 1'b1);
    pulse(4'h0, 2'h0, '0, g);
    chk(smi_req, 1'b0);
    rd(OFS_STATUS, 16'h0000);
    // Set wins over a status read in the same cycle; the read shows the older value
    evt = 4'h4;
    rd(OFS_STATUS, 16'h0000, 1'b1);
    evt = '0;
    chk(smi_req, 1'b1);
    rd(OFS_STATUS, 16'h2000);
    chk(smi_req, 1'b0);
    // Reset in mid-run drops causes that a read alone cannot clear
    pulse(4'h2, 2'h0, g, '0);
    rst_b = 1'b0;
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    chk(smi_req, 1'b0);
    chk(gpio_sts, '0);
    rd(OFS_STATUS, STATUS_RST);
    @(negedge mclk);
    chk(16'(exp_q.size()), 16'h0000);
    give_verdict();
  end
endmodule : smi_top_level_status_test

// ==== hdl/smi_gpio_levels.sv ====
`timescale 1ns/1ps
module smi_gpio_levels
  import smi_status_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Per-pin events and third-level clears
  input wire logic [GPIO_N-1:0] gpio_evt,
  input wire logic [GPIO_N-1:0] gpio_clr,
  // Third-level status and its summary
  output logic [GPIO_N-1:0] gpio_sts_ff,
  output logic gpio_any
);

  // One sticky flag per pin; a new event beats a clear in the same cycle
  for (genvar i = 0; i < GPIO_N; i++) begin : g_pin
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        gpio_sts_ff[i] <= 1'b0;
      end else if (gpio_evt[i]) begin
        gpio_sts_ff[i] <= 1'b1;
      end else if (gpio_clr[i]) begin
        gpio_sts_ff[i] <= 1'b0;
      end
    end
  end

  // Summary is derived, so a pin clear drops upper levels at once
  assign gpio_any = |gpio_sts_ff;

  a_gpio_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    (gpio_clr & ~gpio_evt) != '0 |=> (gpio_sts_ff & $past(gpio_clr & ~gpio_evt)) == '0)
    else $error("GPIO third-level clear did not take");

  a_gpio_set: assert property (@(posedge mclk) disable iff (!rst_b)
    gpio_evt != '0 |=> gpio_any ##0 ((gpio_sts_ff & $past(gpio_evt)) == $past(gpio_evt)))
    else $error("GPIO event not recorded");

endmodule : smi_gpio_levels

// ==== hdl/smi_status_pkg.sv ====
// Functional notes
// - Status read returns bits, then clears read-to-clear bits; lower-level bits stay.
// - Clearing a second-level cause also clears its top-level bit, except GPIO.
// - GPIO causes kept per pin at third level; clearing them clears upper levels.
// - Mirror offset returns the same status without clearing or dropping the request.
// - Bit 15 captures suspend configuration bit with each new cause; cleared by a status read.
// - USB bit sets on USB activity only with enable field 11; read clears.
// - Warm reset bit sets on warm reset command; read clears.
// - Bit 1 flags audio cause; detail lives in audio second-level status.
// - Bit 0 flags power-management cause; timers and traps excluded.
// - Status register reads all zeros after reset.
package smi_status_pkg;

  // Register offsets on the I/O read port
  localparam logic [7:0] OFS_MIRROR = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h02;

  // Field positions in the top-level status word
  localparam int BIT_SUSP = 15;
  localparam int BIT_USB = 14;
  localparam int BIT_WARM = 13;
  localparam int BIT_AUDIO = 1;
  localparam int BIT_PM = 0;

  // Reset value and access masks
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] RC_MASK = 16'he000;
  localparam logic [15:0] CAUSE_MASK = 16'h6003;

  // USB enable field value that lets USB raise an SMI
  localparam logic [1:0] USB_EN_ON = 2'h3;

  // Number of GPIO pins tracked at the third level
  localparam int GPIO_N = 8;

  // Cause events from the subunits, one-cycle pulses
  typedef struct packed {
    logic usb;
    logic warm_rst;
    logic audio;
    logic pm;
  } smi_evt_t;

  // Second-level clears done by software, one-cycle pulses
  typedef struct packed {
    logic audio;
    logic pm;
  } smi_l2_clr_t;

endpackage : smi_status_pkg

// ==== hdl/smi_top_level_status.sv ====
`timescale 1ns/1ps
module smi_top_level_status
  import smi_status_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // I/O read port
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  output logic [15:0] io_rdata_ff,
  output logic io_rd_ack_ff,
  // Cause events, second-level clears and GPIO third-level clears
  input wire smi_evt_t evt,
  input wire smi_l2_clr_t l2_clr,
  input wire logic [GPIO_N-1:0] gpio_evt,
  input wire logic [GPIO_N-1:0] gpio_clr,
  // Configuration levels from other registers
  input wire logic susp_cfg,
  input wire logic [1:0] usb_en,
  // Third-level GPIO view and SMI request
  output logic [GPIO_N-1:0] gpio_sts,
  output logic smi_req
);

  logic [15:0] status_ff;
  logic [15:0] nxt_status;
  logic [15:0] status_view;
  logic gpio_any;
  logic rd_status;
  logic rd_mirror;
  logic usb_fire;
  logic new_cause;

  // Third-level GPIO tracking
  smi_gpio_levels u_gpio (
    .mclk(mclk),
    .rst_b(rst_b),
    .gpio_evt(gpio_evt),
    .gpio_clr(gpio_clr),
    .gpio_sts_ff(gpio_sts),
    .gpio_any(gpio_any)
  );

  // Access decode
  assign rd_status = io_rd && (io_addr == OFS_STATUS);
  assign rd_mirror = io_rd && (io_addr == OFS_MIRROR);
  assign usb_fire = evt.usb && (usb_en == USB_EN_ON);
  assign new_cause = usb_fire | evt.warm_rst | evt.audio | evt.pm | (|gpio_evt);

  // GPIO joins the power-management bit without a sticky copy of its own
  always_comb begin
    status_view = status_ff;
    status_view[BIT_PM] = status_ff[BIT_PM] | gpio_any;
  end

  // Next status: clears first, then sets, so an event in a clear cycle is kept
  always_comb begin
    nxt_status = status_ff;
    if (rd_status) begin
      nxt_status = nxt_status & ~RC_MASK;
    end
    if (l2_clr.audio) begin
      nxt_status[BIT_AUDIO] = 1'b0;
    end
    if (l2_clr.pm) begin
      nxt_status[BIT_PM] = 1'b0;
    end
    if (usb_fire) begin
      nxt_status[BIT_USB] = 1'b1;
    end
    if (evt.warm_rst) begin
      nxt_status[BIT_WARM] = 1'b1;
    end
    if (evt.audio) begin
      nxt_status[BIT_AUDIO] = 1'b1;
    end
    if (evt.pm) begin
      nxt_status[BIT_PM] = 1'b1;
    end
    // Suspend state is captured with each cause so the handler sees it on entry
    if (new_cause && susp_cfg) begin
      nxt_status[BIT_SUSP] = 1'b1;
    end
  end

  // Status register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Read data: both offsets return the value held before any clear
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      io_rdata_ff <= STATUS_RST;
      io_rd_ack_ff <= 1'b0;
    end else begin
      io_rd_ack_ff <= io_rd;
      if (rd_status || rd_mirror) begin
        io_rdata_ff <= status_view;
      end else begin
        io_rdata_ff <= 16'h0000; // Unmapped offsets read zero
      end
    end
  end

  // Suspend mirror bit is a hint, not a cause, so it does not hold the request
  assign smi_req = |(status_view & CAUSE_MASK);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_read_clears: assert property (
    rd_status && !new_cause |=> (status_ff & RC_MASK) == 16'h0000)
    else $error("Status read left a read-to-clear bit set");

  a_read_keeps_l2: assert property (
    rd_status && !l2_clr.audio && !l2_clr.pm && !evt.audio && !evt.pm
    |=> status_ff[BIT_AUDIO:BIT_PM] == $past(status_ff[BIT_AUDIO:BIT_PM]))
    else $error("Status read changed a second-level bit");

  a_l2_clear: assert property (
    l2_clr.audio && !evt.audio |=> !status_ff[BIT_AUDIO])
    else $error("Audio second-level clear did not clear top bit");

  a_mirror_keeps: assert property (
    rd_mirror && !l2_clr.audio && !l2_clr.pm && gpio_clr == '0
    |=> ((status_ff & $past(status_ff)) == $past(status_ff)) && (smi_req || !$past(smi_req)))
    else $error("Mirror read cleared status");

  a_read_data: assert property (
    io_rd && (io_addr == OFS_MIRROR || io_addr == OFS_STATUS)
    |=> io_rd_ack_ff && io_rdata_ff == $past(status_view))
    else $error("Read data differs from status");

  a_susp_capture: assert property (
    new_cause && susp_cfg |=> status_ff[BIT_SUSP])
    else $error("Suspend bit not captured");

  a_usb_gate: assert property (
    !usb_fire |=> !$rose(status_ff[BIT_USB]))
    else $error("USB bit set without enable");

  a_warm_set: assert property (
    evt.warm_rst |=> status_ff[BIT_WARM] ##1 (status_ff[BIT_WARM] || $past(rd_status)))
    else $error("Warm reset cause lost");

  a_reset_zero: assert property (
    $rose(rst_b) |-> status_ff == 16'h0000 && !smi_req)
    else $error("Status not zero after reset");

  a_smi_hold: assert property (
    evt.audio |=> smi_req [*2] or (smi_req ##1 $past(l2_clr.audio)))
    else $error("SMI request dropped with cause pending");

  // A read that empties every cause with nothing new arriving must drop the request
  a_smi_drop: assert property (
    rd_status && !new_cause && gpio_sts == '0
    && (status_ff & CAUSE_MASK & ~RC_MASK) == 16'h0000
    |=> !smi_req)
    else $error("SMI request with no cause");

  c_usb_read: cover property (usb_fire ##1 smi_req ##[1:4] rd_status ##1 !smi_req);
  c_mirror_then_read: cover property (smi_req && rd_mirror ##1 smi_req ##1 rd_status);
  c_gpio_clear: cover property (gpio_any ##1 gpio_clr != '0 ##1 !smi_req);
  c_set_on_clear: cover property (rd_status && evt.warm_rst ##1 status_ff[BIT_WARM]);

endmodule : smi_top_level_status
